// *** inc/cdsb_pkg.sv ***
// Package of constants for the coprocessor dispatch sideband block
package cdsb_pkg;
	// ************************************************************
	// Widths and fixed values
	// ************************************************************
	localparam int CDSB_DATA_W = 32;
	localparam int CDSB_INSTR_W = 32;
	localparam int CDSB_TAG_W = 3;
	localparam logic [2:0] CDSB_TAG_OLDEST = 3'h0;
	localparam logic CDSB_NARROW_ISA = 1'h1;
	localparam logic [31:0] CDSB_INSTR_RST = 32'h0000_0000;
	localparam logic [31:0] CDSB_DATA_RST = 32'h0000_0000;
	// Dispatch classes
	typedef enum logic [1:0] {
		CDSB_CLS_ARITH,
		CDSB_CLS_TO,
		CDSB_CLS_FROM,
		CDSB_CLS_NONE
	} cdsb_class_t;
endpackage : cdsb_pkg

// *** inc/cdsb_disp_if.sv ***
// Interface carrying the dispatch request and its grant
`timescale 1ns/1ps
interface cdsb_disp_if;
	logic req;
	cdsb_pkg::cdsb_class_t cls;
	logic [cdsb_pkg::CDSB_INSTR_W-1:0] instr;
	logic big_endian;
	logic privileged;
	logic take;
	modport core (output req, output cls, output instr, output big_endian,
		output privileged, input take);
	modport stage (input req, input cls, input instr, input big_endian,
		input privileged, output take);
endinterface : cdsb_disp_if

// *** verilog/cdsb_strobe_stage.sv ***
// Strobe stage: at least one cycle after the word, gated by the previous busy
`timescale 1ns/1ps
module cdsb_strobe_stage
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	cdsb_disp_if.stage disp,
	input wire logic arith_stall_in,
	input wire logic to_stall_in,
	input wire logic from_stall_in,
	output logic [2:0] strobe_out
);
	logic [2:0] next_strobe;
	logic [2:0] stall_vec;
	logic [2:0] pending;

	// Busy sampled the same edge the strobe is formed, so it blocks next cycle
	assign stall_vec = {from_stall_in, to_stall_in, arith_stall_in};

	// One-hot class decode, so two strobes can never coincide
	always_comb
	begin
		pending = 3'h0;
		if (disp.req && disp.cls != cdsb_pkg::CDSB_CLS_NONE)
		begin
			pending[disp.cls] = 1'h1;
		end
		next_strobe = pending & ~stall_vec;
	end

	// Parked word issues whenever its class is not stalled
	assign disp.take = |next_strobe;

	// Strobe register
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			strobe_out <= 3'h0;
		else
			strobe_out <= next_strobe;
	end
endmodule : cdsb_strobe_stage

// *** verilog/cdsb_sideband.sv ***
// Top of the coprocessor dispatch sideband and to-coprocessor data path
`timescale 1ns/1ps
module cdsb_sideband
#(
	parameter int DATA_W = cdsb_pkg::CDSB_DATA_W
)
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic dispatch_req_in,
	input wire logic [1:0] dispatch_class_in,
	input wire logic [31:0] dispatch_instr_in,
	input wire logic big_endian_mode_in,
	input wire logic kernel_debug_mode_in,
	output logic dispatch_taken_out,
	input wire logic to_data_valid_in,
	input wire logic [DATA_W-1:0] to_data_in,
	input wire logic arith_dispatch_stall_in,
	input wire logic to_dispatch_stall_in,
	input wire logic from_dispatch_stall_in,
	output logic [31:0] dispatched_instr_word_out,
	output logic copro_big_endian_flag_out,
	output logic copro_narrow_isa_flag_out,
	output logic copro_privileged_flag_out,
	output logic arith_dispatch_strobe_out,
	output logic to_dispatch_strobe_out,
	output logic from_dispatch_strobe_out,
	output logic to_copro_data_strobe_out,
	output logic [DATA_W-1:0] to_copro_data_bus_out,
	output logic [2:0] to_copro_data_order_tag_out
);
	// ************************************************************
	// Dispatch staging
	// ************************************************************
	cdsb_disp_if disp ();
	logic [2:0] strobe;
	logic parked_vld;
	logic next_parked_vld;
	logic accept;
	cdsb_pkg::cdsb_class_t parked_cls;
	cdsb_pkg::cdsb_class_t offer_cls;

	// True for a class that owns a dispatch strobe
	function automatic logic cdsb_dispatchable
	(
		input cdsb_pkg::cdsb_class_t cls
	);
		return cls != cdsb_pkg::CDSB_CLS_NONE;
	endfunction : cdsb_dispatchable

	// Caller's class code; the none code never issues a strobe
	assign offer_cls = cdsb_pkg::cdsb_class_t'(dispatch_class_in);

	// Stage sees only the parked instruction, never the raw offer
	assign disp.req = parked_vld;
	assign disp.cls = parked_cls;
	assign disp.instr = dispatched_instr_word_out;
	assign disp.big_endian = copro_big_endian_flag_out;
	assign disp.privileged = copro_privileged_flag_out;

	// Strobe stage issues the parked word when its class is free
	cdsb_strobe_stage u_stage (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.disp(disp),
		.arith_stall_in(arith_dispatch_stall_in),
		.to_stall_in(to_dispatch_stall_in),
		.from_stall_in(from_dispatch_stall_in),
		.strobe_out(strobe)
	);

	// Strobe flops live in the stage; these are plain wires
	assign arith_dispatch_strobe_out = strobe[0];
	assign to_dispatch_strobe_out = strobe[1];
	assign from_dispatch_strobe_out = strobe[2];

	// Parking costs a cycle, so the word always leads its strobe
	always_comb
	begin
		accept = dispatch_req_in && cdsb_dispatchable(offer_cls)
			&& (!parked_vld || disp.take);
		next_parked_vld = accept || (parked_vld && !disp.take);
	end

	// ************************************************************
	// Parked instruction
	// ************************************************************
	// Slot stays full while its class is busy
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			parked_vld <= 1'h0;
		end
		else
		begin
			parked_vld <= next_parked_vld;
		end
	end

	// Class of the parked word, only meaningful while the slot is full
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			parked_cls <= cdsb_pkg::CDSB_CLS_NONE;
		end
		else if (accept)
		begin
			parked_cls <= offer_cls;
		end
	end

	// Acceptance pulse; the caller may move on once it shows
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			dispatch_taken_out <= 1'h0;
		end
		else
		begin
			dispatch_taken_out <= accept;
		end
	end

	// ************************************************************
	// Word and sideband flags
	// ************************************************************
	// Word loads with the parking, at least a cycle ahead of the strobe
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			dispatched_instr_word_out <= cdsb_pkg::CDSB_INSTR_RST;
		end
		else if (accept)
		begin
			dispatched_instr_word_out <= dispatch_instr_in;
		end
	end

	// Byte order travels with the word it belongs to
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			copro_big_endian_flag_out <= 1'h0;
		end
		else if (accept)
		begin
			copro_big_endian_flag_out <= big_endian_mode_in;
		end
	end

	// Privilege follows the word, so the gate matches the instruction
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			copro_privileged_flag_out <= 1'h0;
		end
		else if (accept)
		begin
			copro_privileged_flag_out <= kernel_debug_mode_in;
		end
	end

	// Only 32-bit subset instructions are ever issued
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			copro_narrow_isa_flag_out <= cdsb_pkg::CDSB_NARROW_ISA;
		end
		else
		begin
			copro_narrow_isa_flag_out <= cdsb_pkg::CDSB_NARROW_ISA;
		end
	end

	// ************************************************************
	// To-coprocessor data
	// ************************************************************
	// Strobe marks exactly the cycles that carry operand data
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			to_copro_data_strobe_out <= 1'h0;
		end
		else
		begin
			to_copro_data_strobe_out <= to_data_valid_in;
		end
	end

	// Data held when idle; the strobe alone qualifies it
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			to_copro_data_bus_out <= DATA_W'(cdsb_pkg::CDSB_DATA_RST);
		end
		else if (to_data_valid_in)
		begin
			to_copro_data_bus_out <= to_data_in;
		end
	end

	// In-order delivery: tag always names the oldest transfer
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			to_copro_data_order_tag_out <= cdsb_pkg::CDSB_TAG_OLDEST;
		end
		else
		begin
			to_copro_data_order_tag_out <= cdsb_pkg::CDSB_TAG_OLDEST;
		end
	end
endmodule : cdsb_sideband

// *** verification/cdsb_sva.sv ***
// Checker of the sideband port timing and data rules
`timescale 1ns/1ps
module cdsb_sva
#(
	parameter int DATA_W = 32
)
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic to_data_valid_in,
	input wire logic [DATA_W-1:0] to_data_in,
	input wire logic arith_dispatch_stall_in,
	input wire logic to_dispatch_stall_in,
	input wire logic from_dispatch_stall_in,
	input wire logic dispatch_taken_out,
	input wire logic [31:0] dispatched_instr_word_out,
	input wire logic copro_big_endian_flag_out,
	input wire logic copro_privileged_flag_out,
	input wire logic copro_narrow_isa_flag_out,
	input wire logic arith_dispatch_strobe_out,
	input wire logic to_dispatch_strobe_out,
	input wire logic from_dispatch_strobe_out,
	input wire logic to_copro_data_strobe_out,
	input wire logic [DATA_W-1:0] to_copro_data_bus_out,
	input wire logic [2:0] to_copro_data_order_tag_out
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	AST_NARROW: assert property (copro_narrow_isa_flag_out)
		else $error("narrow flag low");
	AST_HOLD: assert property (!dispatch_taken_out |->
		$stable({dispatched_instr_word_out, copro_big_endian_flag_out,
		copro_privileged_flag_out})) else $error("word moved untaken");
	AST_TAG: assert property (to_copro_data_strobe_out |->
		to_copro_data_order_tag_out == 3'h0) else $error("tag not zero");
	AST_DSTB: assert property (to_copro_data_strobe_out ==
		$past(to_data_valid_in)) else $error("data strobe wrong");
	AST_DBUS: assert property (to_copro_data_strobe_out |->
		to_copro_data_bus_out == $past(to_data_in)) else $error("bus wrong");
	AST_ONE: assert property ($onehot0({arith_dispatch_strobe_out,
		to_dispatch_strobe_out, from_dispatch_strobe_out}))
		else $error("two strobes");
	AST_ABUSY: assert property (arith_dispatch_stall_in |=>
		!arith_dispatch_strobe_out) else $error("arith strobe while busy");
	AST_TBUSY: assert property (to_dispatch_stall_in |=>
		!to_dispatch_strobe_out) else $error("to strobe while busy");
	AST_FBUSY: assert property (from_dispatch_stall_in |=>
		!from_dispatch_strobe_out) else $error("from strobe while busy");
endmodule : cdsb_sva
bind cdsb_sideband cdsb_sva #(.DATA_W(DATA_W)) u_sva (.*);

// *** verification/cdsb_copro_model.sv ***
// Behavioural coprocessor: stalls dispatch, records the order tag of each data strobe
`timescale 1ns/1ps
module cdsb_copro_model
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic data_strobe_in,
	input wire logic [2:0] order_tag_in,
	output logic [2:0] stall_out,
	output logic [2:0] last_tag_out
);
	// Prompt most cycles, each class busy about one cycle in eight
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
		if (!rst_b_in)
			stall_out <= 3'h0;
		else
			stall_out <= ($urandom % 4 == 0) ? 3'($urandom) : 3'h0;
	// Tag means nothing without the strobe
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
		if (!rst_b_in)
			last_tag_out <= 3'h0;
		else if (data_strobe_in)
			last_tag_out <= order_tag_in;
endmodule : cdsb_copro_model

// *** verification/testbench.sv ***
// Self-checking bench for the coprocessor dispatch sideband
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module testbench;
	logic clk_sys_in = 0, rst_b_in = 0, req = 0, be = 0, kd = 0, vld = 0;
	logic [1:0] cls = 0;
	logic [31:0] ins = 0, din = 0, m_word = 0, m_bus = 0, word, bus;
	logic [31:0] p_word = 0;
	logic [33:0] m_sw = 0;
	logic [2:0] stl, stb, tag, seen, m_stb = 0;
	logic [1:0] m_pc = 0;
	logic tkn, nar, dstb, beo, kdo, m_be = 0, m_kd = 0, m_dstb = 0, m_hold = 0;
	logic m_pv = 0, m_tkn = 0, fire = 0, acc = 0, p_be = 0, p_kd = 0;
	int n_errors = 0, samples_checked = 0, cyc = 0;
	always #4 clk_sys_in = ~clk_sys_in;
	cdsb_sideband u_dut (.clk_sys_in, .rst_b_in, .dispatch_req_in(req),
		.dispatch_class_in(cls), .dispatch_instr_in(ins),
		.big_endian_mode_in(be), .kernel_debug_mode_in(kd),
		.dispatch_taken_out(tkn), .to_data_valid_in(vld), .to_data_in(din),
		.arith_dispatch_stall_in(stl[0]), .to_dispatch_stall_in(stl[1]),
		.from_dispatch_stall_in(stl[2]), .dispatched_instr_word_out(word),
		.copro_big_endian_flag_out(beo), .copro_narrow_isa_flag_out(nar),
		.copro_privileged_flag_out(kdo), .arith_dispatch_strobe_out(stb[0]),
		.to_dispatch_strobe_out(stb[1]), .from_dispatch_strobe_out(stb[2]),
		.to_copro_data_strobe_out(dstb), .to_copro_data_bus_out(bus),
		.to_copro_data_order_tag_out(tag));
	cdsb_copro_model u_cop (.clk_sys_in, .rst_b_in, .data_strobe_in(dstb),
		.order_tag_in(tag), .stall_out(stl), .last_tag_out(seen));
	task final_report;
		if (n_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	// Reference model and hang guard, advanced at every rising edge
	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (cyc > 4000)
		begin
			n_errors++;
			final_report();
		end
		// One parked slot: issue unless busy, refill when empty or issuing
		fire = m_pv && !stl[m_pc];
		acc = req && cls != 2'h3 && (!m_pv || fire);
		m_stb <= fire ? 3'h1 << m_pc : 3'h0;
		m_sw <= {m_word, m_be, m_kd};
		m_tkn <= acc;
		m_hold <= req && cls != 2'h3 && !acc;
		m_pv <= acc || (m_pv && !fire);
		m_dstb <= vld;
		if (acc) {m_word, m_be, m_kd, m_pc} <= {ins, be, kd, cls};
		if (vld) m_bus <= din;
	end
	// Random traffic; a refused offer keeps its request, class and word until taken
	initial
	begin
		void'($urandom(71));
		repeat (3) @(posedge clk_sys_in);
		#1 rst_b_in = 1;
		repeat (3000)
		begin
			@(posedge clk_sys_in);
			#1;
			`CHK(stb, m_stb)
			`CHK(tkn, m_tkn)
			`CHK(word, m_word)
			if (|stb)
				`CHK({p_word, p_be, p_kd}, m_sw)
			`CHK(seen, 3'h0)
			{p_word, p_be, p_kd} = {word, beo, kdo};
			`CHK({beo, kdo, nar}, {m_be, m_kd, 1'b1})
			`CHK({dstb, bus, tag}, {m_dstb, m_bus, 3'h0})
			if (!m_hold)
			begin
				req = 1'($urandom);
				cls = 2'($urandom);
				ins = $urandom;
			end
			{be, kd, vld} = 3'($urandom);
			din = $urandom;
		end
		final_report();
	end
endmodule : testbench
